// >>> logic/owt_pkg.sv
// Functional notes
// - Each optical port holds standby, active or redundant; only port-level user setting.
// - A switch command moves the active role to the other optical port.
// - Each optical link reports loss of signal or normal.
// - Link signal kind, DS2 or E2, is read-only.
// - Four tributaries, each T1 or E1 following the link signal kind.
// - Tributary standby or active, standby default; standby takes no time slots.
// - T1 framing is D4 or ESF, ESF by default.
// - T1 line loopback returns the received line to the network; off by default.
// - T1 local loopback returns terminal data to it and cuts far-end data.
// - T1 loop code generator is planned only; defaults off, no effect.
// - T1 loop code detector, with ten minute timeout option, planned only; off.
// - E1 framing is CRC multiframe or double frame, CRC by default.
// - CAS or CCS reserves time slot 16 for signalling; CAS default.
// - No-signalling option releases time slot 16 for payload.
// - Even-bit inversion inverts even bits of every E1 slot; normal default.
// - E1 line loopback returns the received line to the network; off default.
// - E1 local loopback loops toward PCM bus and sends keep-alive on line.
// - Loss of signal declared 100 us after optical level falls below threshold.
package owt_pkg;

  localparam int CLK_MHZ = 125;
  localparam int LOS_DELAY_US = 100;
  localparam int LOS_CYCLES = LOS_DELAY_US * CLK_MHZ;
  localparam int LOS_CNT_W = 14;
  localparam int NUM_TRIB = 4;

  // Register offsets.
  localparam logic [3:0] OFS_PORT_STATE = 4'h0;
  localparam logic [3:0] OFS_CONTROL = 4'h1;
  localparam logic [3:0] OFS_STATUS = 4'h2;
  localparam logic [3:0] OFS_TRIB0 = 4'h4;

  // Control register bit positions.
  localparam int CTL_SAVE_BIT = 0;
  localparam int CTL_UNDO_BIT = 1;
  localparam int CTL_SWITCH_BIT = 2;

  // Tributary field positions.
  localparam int TF_ACTIVE = 0;
  localparam int TF_FRAME = 1;
  localparam int TF_TS16_LO = 2;
  localparam int TF_EVENINV = 4;
  localparam int TF_LINELB = 5;
  localparam int TF_LOCALLB = 6;
  localparam int TF_GEN_LO = 8;
  localparam int TF_DET_LO = 10;

  typedef enum logic [1:0] {
    OPT_STANDBY   = 2'b00,
    OPT_ACTIVE    = 2'b01,
    OPT_REDUNDANT = 2'b10
  } owt_opt_state_type;

  typedef enum logic [1:0] {
    TS16_CAS = 2'b00,
    TS16_CCS = 2'b01,
    TS16_NOS = 2'b10
  } owt_ts16_type;

  typedef struct packed {
    logic [1:0]   loopDetect;
    logic [1:0]   loopGenerate;
    logic         spare;
    logic         localLoop;
    logic         lineLoop;
    logic         evenInvert;
    owt_ts16_type ts16Use;
    logic         frameAlt;
    logic         active;
  } owt_trib_type;

  localparam owt_trib_type TRIB_RESET = '{
    loopDetect: 2'h0, loopGenerate: 2'h0, spare: 1'b0, localLoop: 1'b0,
    lineLoop: 1'b0, evenInvert: 1'b0, ts16Use: TS16_CAS,
    frameAlt: 1'b0, active: 1'b0};

  localparam owt_opt_state_type PORT0_RESET = OPT_ACTIVE;
  localparam owt_opt_state_type PORT1_RESET = OPT_REDUNDANT;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } owt_bus_req_type;

  // Per tributary serial path: one bit per cycle with slot bit index.
  typedef struct packed {
    logic       bitVal;
    logic [2:0] bitIdx;
    logic [4:0] slot;
  } owt_bit_type;

endpackage

// >>> logic/owt_port_ctrl.sv
// The address map and strobed register access are this design's own decisions.
`timescale 1ns/10ps
`default_nettype none
module owt_port_ctrl (
  // Clock and reset.
  input  wire logic                         ref_clk,
  input  wire logic                         rst,
  // Register port.
  input  wire owt_pkg::owt_bus_req_type     busReq,
  output logic [15:0]                       busRdata,
  // Optical side.
  input  wire logic [1:0]                   optBelowThresh,
  input  wire logic                         linkIsE2,
  output logic [1:0]                        optLos,
  output logic [1:0]                        optActive,
  // Tributary streams.
  input  wire owt_pkg::owt_bit_type [3:0]   netRx,
  input  wire owt_pkg::owt_bit_type [3:0]   termTx,
  output owt_pkg::owt_bit_type [3:0]        netTx,
  output owt_pkg::owt_bit_type [3:0]        termRx,
  output logic [3:0]                        slotInUse
);
  import owt_pkg::*;

  //////////////////////////////////////////////////////////////////////////
  owt_opt_state_type portPend_q [2];
  owt_opt_state_type portLive_q [2];
  owt_trib_type      tribPend_q [NUM_TRIB];
  owt_trib_type      tribLive_q [NUM_TRIB];
  logic [LOS_CNT_W-1:0] losCnt_q [2];
  logic [1:0]        los_q;
  logic [15:0]       rdata_q;

  wire wrPort = busReq.wr && busReq.addr == OFS_PORT_STATE;
  wire wrCtl  = busReq.wr && busReq.addr == OFS_CONTROL;
  wire doSave = wrCtl && busReq.wdata[CTL_SAVE_BIT];
  wire doUndo = wrCtl && busReq.wdata[CTL_UNDO_BIT];
  wire doSwap = wrCtl && busReq.wdata[CTL_SWITCH_BIT];
  wire [3:0] tribIdx = busReq.addr - OFS_TRIB0;
  wire isTrib = busReq.addr >= OFS_TRIB0 &&
                busReq.addr < OFS_TRIB0 + 4'(NUM_TRIB);

  //////////////////////////////////////////////////////////////////////////
  // Pending settings are staged; live ones move on save, and live port states also move on a switch.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      portPend_q[0] <= PORT0_RESET;
      portPend_q[1] <= PORT1_RESET;
      portLive_q[0] <= PORT0_RESET;
      portLive_q[1] <= PORT1_RESET;
    end else if (doSwap && (portLive_q[0] == OPT_ACTIVE ||
                            portLive_q[1] == OPT_ACTIVE)) begin
      // The active role trades places with the other port.
      portLive_q[0] <= portLive_q[1];
      portLive_q[1] <= portLive_q[0];
      portPend_q[0] <= portLive_q[1];
      portPend_q[1] <= portLive_q[0];
    end else if (doSave) begin
      portLive_q <= portPend_q;
    end else if (doUndo) begin
      portPend_q <= portLive_q;
    end else if (wrPort) begin
      // Code 2'b11 is not a state, so it falls back to standby.
      for (int p = 0; p < 2; p++) begin
        portPend_q[p] <= (busReq.wdata[2*p+:2] == 2'b11) ? OPT_STANDBY
                         : owt_opt_state_type'(busReq.wdata[2*p+:2]);
      end
    end
  end

  generate
    for (genvar t = 0; t < NUM_TRIB; t++) begin : gTrib
      owt_trib_type wTrib;
      owt_bit_type  netOut;
      owt_bit_type  termOut;
      logic         occupied;
      always_comb begin
        wTrib = owt_trib_type'(busReq.wdata[11:0]);
        // Loop code functions are not available; they stay off.
        wTrib.loopGenerate = 2'h0;
        wTrib.loopDetect = 2'h0;
        // Bit 7 holds no setting, so it always reads back as zero.
        wTrib.spare = 1'b0;
        if (wTrib.ts16Use == 2'b11) begin
          wTrib.ts16Use = TS16_CAS;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          tribPend_q[t] <= TRIB_RESET;
          tribLive_q[t] <= TRIB_RESET;
        end else if (doSave) begin
          tribLive_q[t] <= tribPend_q[t];
        end else if (doUndo) begin
          tribPend_q[t] <= tribLive_q[t];
        end else if (busReq.wr && isTrib && tribIdx == 4'(t)) begin
          tribPend_q[t] <= wTrib;
        end
      end

      // The same control set serves T1 or E1 by the link kind.
      wire isE1 = linkIsE2;
      wire tsSig = isE1 && netRx[t].slot == 5'd16 &&
                   tribLive_q[t].ts16Use != TS16_NOS;
      wire invBit = isE1 && tribLive_q[t].evenInvert &&
                    netRx[t].bitIdx[0];
      always_comb begin
        occupied = tribLive_q[t].active && !tsSig;
        netOut = termTx[t];
        netOut.bitVal = termTx[t].bitVal ^ (isE1 && tribLive_q[t].evenInvert
                        && termTx[t].bitIdx[0]);
        termOut = netRx[t];
        termOut.bitVal = netRx[t].bitVal ^ invBit;
        if (tribLive_q[t].lineLoop) begin
          netOut = netRx[t];
        end else if (tribLive_q[t].localLoop && isE1) begin
          netOut.bitVal = 1'b1;
        end
        if (tribLive_q[t].localLoop) begin
          termOut = termTx[t];
        end
        if (!tribLive_q[t].active) begin
          netOut.bitVal = 1'b0;
          termOut.bitVal = 1'b0;
        end
      end
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          netTx[t] <= '0;
          termRx[t] <= '0;
          slotInUse[t] <= 1'b0;
        end else begin
          netTx[t] <= netOut;
          termRx[t] <= termOut;
          slotInUse[t] <= occupied;
        end
      end
    end
  endgenerate

  //////////////////////////////////////////////////////////////////////////
  // Level below threshold must last the full time before a loss is shown.
  generate
    for (genvar p = 0; p < 2; p++) begin : gLos
      always_ff @(posedge ref_clk) begin
        if (rst) begin
          losCnt_q[p] <= '0;
          los_q[p] <= 1'b0;
        end else if (!optBelowThresh[p]) begin
          losCnt_q[p] <= '0;
          los_q[p] <= 1'b0;
        end else if (losCnt_q[p] == LOS_CNT_W'(LOS_CYCLES - 1)) begin
          los_q[p] <= 1'b1;
        end else begin
          losCnt_q[p] <= losCnt_q[p] + 1'b1;
        end
      end
      assign optActive[p] = portLive_q[p] == OPT_ACTIVE;
    end
  endgenerate
  assign optLos = los_q;

  //////////////////////////////////////////////////////////////////////////
  wire [15:0] tribRd = isTrib ? {4'h0, tribPend_q[tribIdx[1:0]]} : 16'h0000;
  wire [15:0] rdMux =
    (busReq.addr == OFS_PORT_STATE) ? {12'h000, portPend_q[1], portPend_q[0]} :
    (busReq.addr == OFS_STATUS) ? {11'h000, linkIsE2, los_q,
                                   optActive} : tribRd;
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      rdata_q <= 16'h0000;
    end else if (busReq.rd) begin
      rdata_q <= rdMux;
    end else begin
      rdata_q <= 16'h0000;
    end
  end
  assign busRdata = rdata_q;

endmodule
`default_nettype wire

// >>> sim/owt_far_model.sv
`timescale 1ns/10ps
`default_nettype none
module owt_far_model (
  // Clock, reset and light control.
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  input  wire logic [1:0]            dark,
  // Toward the block.
  output logic [1:0]                 optBelowThresh,
  output owt_pkg::owt_bit_type [3:0] netRx
);
  import owt_pkg::*;
  logic [7:0] pos_q;
  // The far frame runs freely, so each slot recurs every 256 cycles.
  always_ff @(posedge ref_clk) begin
    if (rst) begin
      pos_q <= 8'h00;
    end else begin
      pos_q <= pos_q + 8'h01;
    end
  end
  assign optBelowThresh = dark;
  for (genvar i = 0; i < 4; i++) begin : g_trib
    assign netRx[i] = '{pos_q[0] ^ pos_q[4] ^ 1'(i), pos_q[2:0], pos_q[7:3]};
  end
endmodule
`default_nettype wire

// >>> sim/owt_port_ctrl_chk.sv
`timescale 1ns/10ps
`default_nettype none
module owt_port_ctrl_chk (
  // Clock and reset.
  input wire logic                  ref_clk,
  input wire logic                  rst,
  // Watched ports.
  input wire owt_pkg::owt_bus_req_type busReq,
  input wire logic [15:0]           busRdata,
  input wire logic [1:0]            optBelowThresh,
  input wire logic                  linkIsE2,
  input wire logic [1:0]            optLos,
  input wire logic [1:0]            optActive,
  input wire owt_pkg::owt_bit_type [3:0] netRx,
  input wire owt_pkg::owt_bit_type [3:0] netTx,
  input wire logic [3:0]            slotInUse
);
  import owt_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  logic [13:0] dim_q;
  always_ff @(posedge ref_clk) begin
    if (rst || !optBelowThresh[0]) begin
      dim_q <= 14'h0000;
    end else if (dim_q != 14'h3fff) begin
      dim_q <= dim_q + 14'h0001;
    end
  end
  ////////////////////////////////////////
  sequence s_swap;
    busReq.wr && busReq.addr == OFS_CONTROL && busReq.wdata[CTL_SWITCH_BIT];
  endsequence
  sequence s_stat;
    busReq.rd && busReq.addr == OFS_STATUS;
  endsequence
  property p_swap;
    s_swap ##0 optActive == 2'b01 |=> optActive == 2'b10;
  endproperty
  a_swap: assert property (p_swap)
    else $error("switch did not move activity");
  property p_stat;
    s_stat |=> busRdata[4:0] ==
      {$past(linkIsE2), $past(optLos), $past(optActive)};
  endproperty
  a_stat: assert property (p_stat)
    else $error("status read wrong");
  property p_idle;
    !$past(busReq.rd) |-> busRdata == 16'h0000;
  endproperty
  a_idle: assert property (p_idle)
    else $error("read data outside its cycle");
  property p_still;
    !$past(busReq.wr) |-> $stable(optActive);
  endproperty
  a_still: assert property (p_still)
    else $error("activity moved without a command");
  property p_clear;
    !optBelowThresh[0] |=> !optLos[0];
  endproperty
  a_clear: assert property (p_clear)
    else $error("loss stayed after light returned");
  property p_hold;
    optLos[1] |-> $past(optBelowThresh[1]);
  endproperty
  a_hold: assert property (p_hold)
    else $error("loss without dim light");
  property p_rise;
    $rose(optLos[0]) |-> dim_q inside {[LOS_CYCLES - 2:LOS_CYCLES + 1]};
  endproperty
  a_rise: assert property (p_rise)
    else $error("loss declared at wrong time");
  property p_quiet;
    !slotInUse[0] && $past(netRx[0].slot) != 5'd16 |-> !netTx[0].bitVal;
  endproperty
  a_quiet: assert property (p_quiet)
    else $error("standby tributary sent data");
endmodule
bind owt_port_ctrl owt_port_ctrl_chk u_chk (.ref_clk(ref_clk), .rst(rst),
  .busReq(busReq), .busRdata(busRdata), .optBelowThresh(optBelowThresh),
  .linkIsE2(linkIsE2), .optLos(optLos), .optActive(optActive),
  .netRx(netRx), .netTx(netTx), .slotInUse(slotInUse));
`default_nettype wire

// >>> sim/optical_wan_tributary_port_control_tb.sv
`timescale 1ns/10ps
`default_nettype none
module optical_wan_tributary_port_control_tb;
  import owt_pkg::*;
  typedef struct packed {
    logic [15:0] cfg;
    logic        e2;
    logic [2:0]  tx;
    logic [2:0]  rx;
    logic [1:0]  inUse;
  } owt_row_type;
  // Kinds: 0 zero, 1 far data, 2 terminal data, 3 ones, 4 inverted, 5 skip.
  localparam owt_row_type ROWS [9] = '{
    '{16'h0000, 1'b0, 3'd0, 3'd0, 2'd0}, '{16'h0021, 1'b0, 3'd1, 3'd5, 2'd2},
    '{16'h0041, 1'b0, 3'd5, 3'd2, 2'd2}, '{16'h0041, 1'b1, 3'd3, 3'd2, 2'd0},
    '{16'h0021, 1'b1, 3'd1, 3'd5, 2'd0}, '{16'h0011, 1'b1, 3'd4, 3'd5, 2'd0},
    '{16'h0001, 1'b1, 3'd2, 3'd5, 2'd0}, '{16'h0005, 1'b1, 3'd5, 3'd5, 2'd0},
    '{16'h0009, 1'b1, 3'd5, 3'd5, 2'd1}};
  logic ref_clk = 1'b0;
  logic rst = 1'b1;
  logic linkIsE2 = 1'b0;
  logic [1:0] dark = 2'b00;
  logic [7:0] cnt_q = 8'h00;
  owt_bus_req_type busReq = '0;
  owt_bit_type [3:0] termTx = '0;
  owt_bit_type [3:0] netRx, netTx, termRx;
  owt_bit_type r, t;
  logic [15:0] busRdata, q;
  logic [1:0] optBelowThresh, optLos, optActive;
  logic [3:0] slotInUse;
  int miscompares = 0;
  int comparisons = 0;
  int k;
  always #4 ref_clk = ~ref_clk;
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 8'h01;
    termTx <= {4{cnt_q[3] ^ cnt_q[0], cnt_q[2:0], cnt_q[7:3]}};
  end
  owt_port_ctrl dut (.ref_clk(ref_clk), .rst(rst), .busReq(busReq),
    .busRdata(busRdata), .optBelowThresh(optBelowThresh),
    .linkIsE2(linkIsE2), .optLos(optLos), .optActive(optActive),
    .netRx(netRx), .termTx(termTx), .netTx(netTx), .termRx(termRx),
    .slotInUse(slotInUse));
  owt_far_model far (.ref_clk(ref_clk), .rst(rst), .dark(dark),
    .optBelowThresh(optBelowThresh), .netRx(netRx));
  ////////////////////////////////////////
  task automatic chk(input string n, input logic [15:0] e, input logic [15:0] g);
    comparisons++;
    if (g !== e) begin
      miscompares++;
      $display("[ERR] %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic final_report();
    $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  task automatic bus(input logic [3:0] a, input logic [15:0] d, input logic w);
    busReq <= '{a, d, w, !w};
    @(posedge ref_clk);
    busReq <= '0;
    #1 q = busRdata;
    @(posedge ref_clk);
  endtask
  // Sample both streams at the first bit of far slot s, then let the edge that uses them pass.
  task automatic at(input logic [4:0] s);
    k = 0;
    do @(negedge ref_clk); while (netRx[0].slot !== s && ++k < 300);
    if (k == 300) begin
      miscompares++;
      final_report();
    end
    r = netRx[0];
    t = termTx[0];
    @(posedge ref_clk);
    #1;
  endtask
  function automatic logic pick(input logic [2:0] c);
    case (c)
      3'd0: pick = 1'b0;
      3'd1: pick = r.bitVal;
      3'd2: pick = t.bitVal;
      3'd3: pick = 1'b1;
      default: pick = t.bitVal ^ t.bitIdx[0];
    endcase
  endfunction
  initial begin
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    @(posedge ref_clk);
    bus(OFS_PORT_STATE, 16'h0000, 1'b0);
    chk("port state", 16'h0009, q);
    bus(4'h3, 16'h0000, 1'b0);
    chk("unmapped", 16'h0000, q);
    for (int j = 0; j < 9; j++) begin
      linkIsE2 <= ROWS[j].e2;
      bus(OFS_TRIB0, ROWS[j].cfg, 1'b1);
      bus(OFS_CONTROL, 16'h0001, 1'b1);
      at(5'd16);
      if (ROWS[j].inUse != 2'd2) chk("slot", 16'(ROWS[j].inUse), 16'(slotInUse[0]));
      at(5'd17);
      if (ROWS[j].tx != 3'd5) chk("netTx", 16'(pick(ROWS[j].tx)), 16'(netTx[0].bitVal));
      if (ROWS[j].rx != 3'd5) chk("termRx", 16'(pick(ROWS[j].rx)), 16'(termRx[0].bitVal));
    end
    bus(OFS_TRIB0, 16'h0f41, 1'b1);
    bus(OFS_TRIB0, 16'h0000, 1'b0);
    chk("pending", 16'h0041, q);
    bus(OFS_CONTROL, 16'h0002, 1'b1);
    bus(OFS_TRIB0, 16'h0000, 1'b0);
    chk("undo", 16'h0009, q);
    bus(OFS_PORT_STATE, 16'h000b, 1'b1);
    bus(OFS_PORT_STATE, 16'h0000, 1'b0);
    chk("bad state", 16'h0008, q);
    bus(OFS_CONTROL, 16'h0004, 1'b1);
    dark <= 2'b01;
    repeat (12400) @(posedge ref_clk);
    chk("early loss", 16'h0000, 16'(optLos));
    for (k = 0; k < 300 && optLos !== 2'b01; k++) @(posedge ref_clk);
    if (k == 300) begin
      miscompares++;
      final_report();
    end
    bus(OFS_STATUS, 16'h0000, 1'b0);
    chk("status", 16'h0016, q);
    dark <= 2'b00;
    @(posedge ref_clk);
    #1 chk("loss clear", 16'h0000, 16'(optLos));
    final_report();
  end
endmodule
`default_nettype wire
